/* logic/mcuid_consts.svh */
// Constants for the instruction decode and timing block
`ifndef MCUID_CONSTS_SVH
`define MCUID_CONSTS_SVH

`define MCUID_OPC_EXT 8'h00
`define MCUID_OPC_INDIR 8'h01
`define MCUID_OPC_CALL2 8'h02
`define MCUID_OPC_GOTO2 8'h04
`define MCUID_OPC_LOOP2 8'h08
`define MCUID_OPC_RET 8'h06
`define MCUID_OPC_IRET 8'h07
`define MCUID_OPC_TBLRD 8'hBA
`define MCUID_OPC_TBLWR 8'hBB
`define MCUID_OPC_MOVD 8'hBE
`define MCUID_OPC_SKPS 8'hA6
`define MCUID_OPC_SKPC 8'hA7
`define MCUID_OPC_SQR 8'hB8
`define MCUID_OPC_DIV 8'hD8
`define MCUID_RELBR_GRP 4'h3
`define MCUID_FILE_GRP 4'hE
`define MCUID_CC_ALWAYS 4'h7

`define MCUID_XC_BRANCH 2'h1
`define MCUID_XC_RET 2'h2
`define MCUID_XC_TBL 2'h1
`define MCUID_XC_MOVD 2'h1

`define MCUID_FLAG_C 0
`define MCUID_FLAG_DIGIT_CARRY 1
`define MCUID_FLAG_N 2
`define MCUID_FLAG_OVERFLOW 3
`define MCUID_FLAG_Z 4
`define MCUID_FLAGS_RST 5'h00
`define MCUID_SQR_BASE 2'h1

`define MCUID_ADDR_CTRL 12'h000
`define MCUID_ADDR_STAT 12'h004
`define MCUID_ADDR_ICNT 12'h008
`define MCUID_ADDR_CCNT 12'h00C
`define MCUID_WORK_PAGE 6'h01
`define MCUID_CTRL_RUN 0
`define MCUID_STAT_ERR 8
`define MCUID_DIV_RST 8'h00

`endif

/* logic/mcuid_pkg.sv */
// Types shared by the instruction decode and timing block
`default_nettype none
package mcuid_pkg;
  typedef enum logic [2:0] {
    ST_ISSUE = 3'b000,
    ST_WORD2 = 3'b001,
    ST_SKIP1 = 3'b010,
    ST_SKIP2 = 3'b011,
    ST_EXTRA = 3'b100
  } mcuid_state_e;
  typedef enum logic [1:0] {
    SZ_WORD = 2'b00,
    SZ_BYTE = 2'b01,
    SZ_DOUBLE = 2'b10
  } mcuid_size_e;
  typedef enum logic [2:0] {
    AM_DIRECT = 3'b000,
    AM_INDIR = 3'b001,
    AM_POSTDEC = 3'b010,
    AM_POSTINC = 3'b011,
    AM_PREDEC = 3'b100,
    AM_PREINC = 3'b101,
    AM_REGOFS = 3'b110
  } mcuid_mode_e;
  typedef logic [23:0] mcuid_word_t;
endpackage
`default_nettype wire

/* logic/mcuid_decoder.sv */
// Instruction fetch sequencing, cycle timing and operand decode with APB registers
//
// Summary of operation
// - Two-word instructions carry all operands in 48 bits over two fetched words.
// - Second word has its top eight bits zero.
// - A lone second word executes as a no-operation.
// - Plain one-word instruction takes one instruction cycle.
// - Taken condition or PC change adds one no-operation cycle, two for a return.
// - Taken branches, indirect jumps, table ops and returns take two or three cycles; an untaken branch takes one.
// - Taken skip costs two cycles, three over a two-word instruction.
// - Double-word moves and two-word instructions take two cycles.
// - Bit position field is four bits, positions 0 to 15.
// - File register address spans 0 to 0x1FFF.
// - Default file-op register is working register zero.
// - Ten-bit unsigned literal: 0-255 byte mode, 0-1023 word mode.
// - Program address literal is 23 bits with LSB zero.
// - Signed literals are two's complement, ten and sixteen bits.
// - Square uses one register twice, only registers 4 to 7.
// - Extended operand modes add register-plus-base-register offset.
// - Working register fields select one of sixteen registers.
// - Carry, digit-carry, negative, overflow and zero flags kept; zero sticky in extended ops.
// - Size byte, double or word; word when no suffix.
// - Divide takes its register pair by direct addressing only.
// - One-word instruction is 24 bits with an 8-bit opcode.
`default_nettype none
`include "mcuid_consts.svh"

module mcuid_decoder (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fetch_valid,
  input wire mcuid_pkg::mcuid_word_t fetch_word,
  output logic fetch_ready,
  input wire logic alu_flag_we,
  input wire logic [4:0] alu_flags,
  input wire logic alu_sticky,
  output logic [4:0] status_flags,
  output logic icyc_tick,
  output logic op_valid,
  output mcuid_pkg::mcuid_word_t op_word,
  output mcuid_pkg::mcuid_word_t op_ext,
  output logic op_two_word,
  output logic op_nop,
  output mcuid_pkg::mcuid_size_e op_size,
  output logic [3:0] op_src_reg,
  output mcuid_pkg::mcuid_mode_e op_src_mode,
  output logic [3:0] op_dst_reg,
  output mcuid_pkg::mcuid_mode_e op_dst_mode,
  output logic [3:0] op_base_reg,
  output logic [3:0] op_bit_pos,
  output logic [12:0] op_file_addr,
  output logic [15:0] op_ulit,
  output logic [15:0] op_slit,
  output logic [22:0] op_prog_addr,
  output logic nop_cycle,
  output logic pc_change
);
  import mcuid_pkg::*;

  function automatic logic is_two(input logic [7:0] opc);
    is_two = (opc == `MCUID_OPC_CALL2) || (opc == `MCUID_OPC_GOTO2) || (opc == `MCUID_OPC_LOOP2);
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw, input logic [1:0] be);
    merge16 = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
  endfunction

  mcuid_state_e state, next_state;
  logic [1:0] xcnt, next_xcnt;
  logic run;
  logic [7:0] div;
  logic [7:0] div_cnt;
  logic ext_err;
  logic [4:0] flags;
  logic [31:0] icnt;
  logic [31:0] ccnt;
  mcuid_word_t held_w1;
  logic [15:0] work_reg [16];

  // Instruction cycle enable
  wire tick = run && (div_cnt == div);
  wire take = fetch_ready && fetch_valid;

  // Word 2 of a skipped or pending pair is never issued on its own
  assign fetch_ready = tick && (state != ST_EXTRA);

  wire [23:0] cur_w1 = (state == ST_WORD2) ? held_w1 : fetch_word;
  wire [23:0] cur_w2 = (state == ST_WORD2) ? fetch_word : 24'h000000;
  wire [7:0] opc = cur_w1[23:16];
  wire fetch_two = is_two(fetch_word[23:16]);
  wire ext_bad = (state == ST_WORD2) && take && (fetch_word[23:16] != 8'h00);

  // Timing classes
  wire is_cbr = (opc[7:4] == `MCUID_RELBR_GRP);
  wire [3:0] cc = opc[3:0];
  logic cc_true;
  always_comb begin
    unique case (cc)
      4'h0: cc_true = flags[`MCUID_FLAG_C];
      4'h1: cc_true = flags[`MCUID_FLAG_Z];
      4'h2: cc_true = flags[`MCUID_FLAG_N];
      4'h3: cc_true = flags[`MCUID_FLAG_OVERFLOW];
      4'h4: cc_true = !flags[`MCUID_FLAG_C];
      4'h5: cc_true = !flags[`MCUID_FLAG_Z];
      4'h6: cc_true = !flags[`MCUID_FLAG_N];
      `MCUID_CC_ALWAYS: cc_true = 1'b1;
      default: cc_true = 1'b0;
    endcase
  end
  wire br_taken = is_cbr && cc_true;
  wire is_indir = (opc == `MCUID_OPC_INDIR);
  wire is_ret = (opc == `MCUID_OPC_RET) || (opc == `MCUID_OPC_IRET);
  wire is_tbl = (opc == `MCUID_OPC_TBLRD) || (opc == `MCUID_OPC_TBLWR);
  wire is_movd = (opc == `MCUID_OPC_MOVD);
  wire is_skp = (opc == `MCUID_OPC_SKPS) || (opc == `MCUID_OPC_SKPC);
  wire is_file = (opc[7:4] == `MCUID_FILE_GRP);
  wire is_sqr = (opc == `MCUID_OPC_SQR);
  wire is_div = (opc == `MCUID_OPC_DIV);

  // Extra no-operation cycles after the issue cycle
  logic [1:0] xcyc;
  always_comb begin
    xcyc = 2'h0;
    if (br_taken || is_indir) begin
      xcyc = `MCUID_XC_BRANCH;
    end else if (is_ret) begin
      xcyc = `MCUID_XC_RET;
    end else if (is_tbl) begin
      xcyc = `MCUID_XC_TBL;
    end else if (is_movd) begin
      xcyc = `MCUID_XC_MOVD;
    end
  end

  // Skip test reads the named working register bit
  wire [3:0] bitpos = cur_w1[15:12];
  wire [15:0] skp_reg = work_reg[cur_w1[3:0]];
  wire skp_bit = skp_reg[bitpos];
  wire skip_taken = is_skp && ((opc == `MCUID_OPC_SKPS) ? skp_bit : !skp_bit);

  always_comb begin
    next_state = state;
    next_xcnt = xcnt;
    unique case (state)
      ST_ISSUE: begin
        if (take) begin
          if (fetch_two) begin
            next_state = ST_WORD2;
          end else if (skip_taken) begin
            next_state = ST_SKIP1;
          end else if (xcyc != 2'h0) begin
            next_state = ST_EXTRA;
            next_xcnt = xcyc;
          end
        end
      end
      ST_WORD2: begin
        if (take) begin
          next_state = ST_ISSUE;
        end
      end
      ST_SKIP1: begin
        if (take) begin
          next_state = fetch_two ? ST_SKIP2 : ST_ISSUE;
        end
      end
      ST_SKIP2: begin
        if (take) begin
          next_state = ST_ISSUE;
        end
      end
      ST_EXTRA: begin
        if (tick) begin
          next_xcnt = xcnt - 2'h1;
          if (xcnt == 2'h1) begin
            next_state = ST_ISSUE;
          end
        end
      end
      default: next_state = ST_ISSUE;
    endcase
  end

  // One issue per instruction; plain words finish in their own cycle
  wire issue = take && (((state == ST_ISSUE) && !fetch_two) || (state == ST_WORD2));
  wire skip_nop = take && ((state == ST_SKIP1) || (state == ST_SKIP2));
  wire next_nop_cycle = skip_nop || (tick && (state == ST_EXTRA));
  wire two_pc = (state == ST_WORD2) && (opc != `MCUID_OPC_LOOP2);
  wire next_pc_change = issue && (br_taken || is_indir || is_ret || two_pc || skip_taken);

  // Operand decode
  wire [1:0] szf = opc[1:0];
  wire mcuid_size_e dec_size = (szf == 2'b01) ? SZ_BYTE : (szf == 2'b10) ? SZ_DOUBLE : SZ_WORD;
  wire [2:0] smf = cur_w1[6:4];
  wire [2:0] dmf = cur_w1[13:11];
  wire s_ofs = (smf == AM_REGOFS);
  wire d_ofs = !s_ofs && (dmf == AM_REGOFS);
  wire direct_only = is_div || is_sqr || is_file;
  wire mcuid_mode_e dec_smode = (direct_only || d_ofs || (smf == 3'b111)) ? AM_DIRECT : mcuid_mode_e'(smf);
  wire mcuid_mode_e dec_dmode = (direct_only || s_ofs || (dmf == 3'b111)) ? AM_DIRECT : mcuid_mode_e'(dmf);
  wire [3:0] dec_base = s_ofs ? cur_w1[14:11] : cur_w1[3:0];
  wire [3:0] sq_reg = {`MCUID_SQR_BASE, cur_w1[1:0]};
  wire [3:0] dec_src = is_sqr ? sq_reg : cur_w1[3:0];
  wire [3:0] dec_dst = is_sqr ? sq_reg : (is_file && cur_w1[13]) ? 4'h0 : cur_w1[10:7];
  wire [9:0] lit_raw = cur_w1[13:4];
  wire [15:0] dec_ulit = (dec_size == SZ_BYTE) ? {8'h00, lit_raw[7:0]} : {6'h00, lit_raw};
  wire [15:0] dec_slit = (state == ST_WORD2) ? cur_w2[15:0] : {{6{lit_raw[9]}}, lit_raw};
  wire [22:0] dec_paddr = {cur_w2[6:0], cur_w1[15:1], 1'b0};
  wire [12:0] dec_faddr = cur_w1[12:0];

  // APB decode
  wire setup = psel && !penable;
  wire acc = psel && penable;
  wire w_hit = (paddr[11:6] == `MCUID_WORK_PAGE) && (paddr[1:0] == 2'h0);
  wire [3:0] w_idx = paddr[5:2];
  wire hit_ctrl = (paddr == `MCUID_ADDR_CTRL);
  wire hit_stat = (paddr == `MCUID_ADDR_STAT);
  wire hit_icnt = (paddr == `MCUID_ADDR_ICNT);
  wire hit_ccnt = (paddr == `MCUID_ADDR_CCNT);
  wire hit = w_hit || hit_ctrl || hit_stat || hit_icnt || hit_ccnt;
  wire wr = acc && pwrite && hit;
  wire wr_ctrl = wr && hit_ctrl;
  wire wr_stat = wr && hit_stat;
  wire [31:0] ctrl_rd = {16'h0000, div, 7'h00, run};
  wire [31:0] stat_rd = {13'h0000, state, 7'h00, ext_err, 3'h0, flags};
  wire [31:0] rd_data = w_hit ? {16'h0000, work_reg[w_idx]} : hit_ctrl ? ctrl_rd : hit_stat ? stat_rd :
                        hit_icnt ? icnt : hit_ccnt ? ccnt : 32'h00000000;

  assign pready = 1'b1;
  assign pslverr = acc && !hit;
  assign status_flags = flags;

  // Read data is captured in the setup phase so the access phase needs no wait
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h00000000;
    end else if (setup && !pwrite) begin
      prdata <= rd_data;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      run <= 1'b0;
      div <= `MCUID_DIV_RST;
    end else if (wr_ctrl) begin
      run <= pstrb[0] ? pwdata[`MCUID_CTRL_RUN] : run;
      div <= pstrb[1] ? pwdata[15:8] : div;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt <= 8'h00;
    end else if (!run || tick) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  // ALU update beats a software write in the same cycle
  wire z_new = alu_sticky ? (flags[`MCUID_FLAG_Z] && alu_flags[`MCUID_FLAG_Z]) : alu_flags[`MCUID_FLAG_Z];
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      flags <= `MCUID_FLAGS_RST;
    end else if (alu_flag_we) begin
      flags <= {z_new, alu_flags[3:0]};
    end else if (wr_stat && pstrb[0]) begin
      flags <= pwdata[4:0];
    end
  end

  // Error flag: write one to clear, a new error wins
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ext_err <= 1'b0;
    end else if (ext_bad) begin
      ext_err <= 1'b1;
    end else if (wr_stat && pstrb[1] && pwdata[`MCUID_STAT_ERR]) begin
      ext_err <= 1'b0;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_work
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          work_reg[gi] <= 16'h0000;
        end else if (wr && w_hit && (w_idx == 4'(gi))) begin
          work_reg[gi] <= merge16(work_reg[gi], pwdata[15:0], pstrb[1:0]);
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_ISSUE;
      xcnt <= 2'h0;
      held_w1 <= 24'h000000;
    end else begin
      state <= next_state;
      xcnt <= next_xcnt;
      if ((state == ST_ISSUE) && take && fetch_two) begin
        held_w1 <= fetch_word;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      icnt <= 32'h00000000;
      ccnt <= 32'h00000000;
    end else begin
      icnt <= icnt + {31'h00000000, issue};
      ccnt <= ccnt + {31'h00000000, tick};
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      op_valid <= 1'b0;
      op_nop <= 1'b0;
      nop_cycle <= 1'b0;
      pc_change <= 1'b0;
      icyc_tick <= 1'b0;
    end else begin
      op_valid <= issue;
      op_nop <= issue && (opc == `MCUID_OPC_EXT);
      nop_cycle <= next_nop_cycle;
      pc_change <= next_pc_change;
      icyc_tick <= tick;
    end
  end

  // Fields hold until the next issue
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      op_word <= 24'h000000;
      op_ext <= 24'h000000;
      op_two_word <= 1'b0;
      op_size <= SZ_WORD;
      op_src_reg <= 4'h0;
      op_src_mode <= AM_DIRECT;
      op_dst_reg <= 4'h0;
      op_dst_mode <= AM_DIRECT;
      op_base_reg <= 4'h0;
      op_bit_pos <= 4'h0;
      op_file_addr <= 13'h0000;
      op_ulit <= 16'h0000;
      op_slit <= 16'h0000;
      op_prog_addr <= 23'h000000;
    end else if (issue) begin
      op_word <= cur_w1;
      op_ext <= cur_w2;
      op_two_word <= (state == ST_WORD2);
      op_size <= dec_size;
      op_src_reg <= dec_src;
      op_src_mode <= dec_smode;
      op_dst_reg <= dec_dst;
      op_dst_mode <= dec_dmode;
      op_base_reg <= dec_base;
      op_bit_pos <= bitpos;
      op_file_addr <= dec_faddr;
      op_ulit <= dec_ulit;
      op_slit <= dec_slit;
      op_prog_addr <= dec_paddr;
    end
  end
endmodule
`default_nettype wire

/* dv/mcuid_decoder_checker.sv */
// Assertion checker for the instruction decode and timing block
`default_nettype none
`include "mcuid_consts.svh"
module mcuid_decoder_checker (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic fetch_valid,
  input wire logic fetch_ready,
  input wire mcuid_pkg::mcuid_word_t fetch_word,
  input wire logic op_valid,
  input wire mcuid_pkg::mcuid_word_t op_word,
  input wire mcuid_pkg::mcuid_word_t op_ext,
  input wire logic op_two_word,
  input wire logic op_nop,
  input wire logic [22:0] op_prog_addr,
  input wire logic [3:0] op_src_reg,
  input wire logic [3:0] op_dst_reg,
  input wire logic [12:0] op_file_addr,
  input wire logic nop_cycle,
  input wire logic pc_change,
  input wire logic alu_flag_we,
  input wire logic alu_sticky,
  input wire logic [4:0] alu_flags,
  input wire logic [4:0] status_flags
);
  timeunit 1ns;
  timeprecision 1ps;
  import mcuid_pkg::*;
  logic take;
  assign take = fetch_valid && fetch_ready;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  sequence s_burn2;
    nop_cycle [*2] ##1 !nop_cycle;
  endsequence
  sequence s_burn1;
    nop_cycle ##1 !nop_cycle;
  endsequence
  property p_ret;
    op_valid && (op_word[23:16] == `MCUID_OPC_RET || op_word[23:16] == `MCUID_OPC_IRET) |=> s_burn2;
  endproperty
  a_ret: assert property (p_ret) else $error("return burn cycles wrong");
  // Burned cycles pulse one clock after the issue pulse, so the burn sequence starts a cycle later
  property p_bra;
    op_valid && op_word[23:16] == {`MCUID_RELBR_GRP, `MCUID_CC_ALWAYS} |-> pc_change ##1 s_burn1;
  endproperty
  a_bra: assert property (p_bra) else $error("branch extra cycle wrong");
  property p_plain;
    op_valid && op_word[23:20] == 4'h4 |-> !pc_change && !nop_cycle ##1 !nop_cycle;
  endproperty
  a_plain: assert property (p_plain) else $error("plain op burned a cycle");
  property p_nop;
    op_valid |-> op_nop == (op_word[23:16] == `MCUID_OPC_EXT);
  endproperty
  a_nop: assert property (p_nop) else $error("lone extension word not a no-op");
  property p_one;
    op_valid && !op_two_word |-> op_word == $past(fetch_word) && op_ext == 24'h0;
  endproperty
  a_one: assert property (p_one) else $error("one-word issue wrong");
  property p_ext;
    op_valid && op_two_word |-> $past(take) && $past(take, 2) && op_ext == $past(fetch_word);
  endproperty
  a_ext: assert property (p_ext) else $error("extension word not consumed");
  property p_addr;
    op_valid && op_two_word && op_word[23:16] != `MCUID_OPC_LOOP2 |->
      op_prog_addr == {op_ext[6:0], op_word[15:1], 1'h0};
  endproperty
  a_addr: assert property (p_addr) else $error("program address wrong");
  property p_sqr;
    op_valid && op_word[23:16] == `MCUID_OPC_SQR |-> op_src_reg == {2'h1, op_word[1:0]};
  endproperty
  a_sqr: assert property (p_sqr) else $error("square register out of range");
  property p_file;
    op_valid && op_word[23:20] == `MCUID_FILE_GRP |->
      op_file_addr == op_word[12:0] && (!op_word[13] || op_dst_reg == 4'h0);
  endproperty
  a_file: assert property (p_file) else $error("file operand wrong");
  property p_sticky;
    alu_flag_we && alu_sticky |=>
      status_flags[`MCUID_FLAG_Z] == ($past(status_flags[`MCUID_FLAG_Z]) && $past(alu_flags[`MCUID_FLAG_Z]));
  endproperty
  a_sticky: assert property (p_sticky) else $error("zero flag not sticky");
endmodule
bind mcuid_decoder mcuid_decoder_checker chk_u (.mclk(mclk), .arst_n(arst_n), .fetch_valid(fetch_valid),
  .fetch_ready(fetch_ready), .fetch_word(fetch_word), .op_valid(op_valid), .op_word(op_word), .op_ext(op_ext),
  .op_two_word(op_two_word), .op_nop(op_nop), .op_prog_addr(op_prog_addr), .op_src_reg(op_src_reg),
  .op_dst_reg(op_dst_reg), .op_file_addr(op_file_addr), .nop_cycle(nop_cycle), .pc_change(pc_change),
  .alu_flag_we(alu_flag_we), .alu_sticky(alu_sticky), .alu_flags(alu_flags), .status_flags(status_flags));
`default_nettype wire

/* dv/mcuid_decoder_tb.sv */
// Self-checking bench for the instruction decode and timing block
`default_nettype none
module mcuid_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mcuid_pkg::*;
  logic mclk, arst_n, psel, penable, pwrite, fetch_valid, alu_flag_we, alu_sticky, er, last_nop;
  logic pready, pslverr, fetch_ready, icyc_tick, op_valid, op_two_word, op_nop, nop_cycle, pc_change;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, op_src_reg, op_dst_reg, op_base_reg, op_bit_pos;
  logic [4:0] alu_flags, status_flags;
  logic [12:0] op_file_addr;
  logic [15:0] op_ulit, op_slit;
  logic [22:0] op_prog_addr;
  mcuid_word_t fetch_word, op_word, op_ext;
  mcuid_size_e op_size;
  mcuid_mode_e op_src_mode, op_dst_mode;
  int err_count = 0;
  int cmp_count = 0;
  int nops = 0;
  int ops = 0;
  int ticks = 0;
  mcuid_decoder dut_u (.mclk(mclk), .arst_n(arst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fetch_valid(fetch_valid), .fetch_word(fetch_word), .fetch_ready(fetch_ready), .alu_flag_we(alu_flag_we),
    .alu_flags(alu_flags), .alu_sticky(alu_sticky), .status_flags(status_flags), .icyc_tick(icyc_tick),
    .op_valid(op_valid), .op_word(op_word), .op_ext(op_ext), .op_two_word(op_two_word), .op_nop(op_nop),
    .op_size(op_size), .op_src_reg(op_src_reg), .op_src_mode(op_src_mode), .op_dst_reg(op_dst_reg),
    .op_dst_mode(op_dst_mode), .op_base_reg(op_base_reg), .op_bit_pos(op_bit_pos), .op_file_addr(op_file_addr),
    .op_ulit(op_ulit), .op_slit(op_slit), .op_prog_addr(op_prog_addr), .nop_cycle(nop_cycle),
    .pc_change(pc_change));
  initial begin
    mclk = 1'h0;
    forever #2.5 mclk = ~mclk;
  end
  // Burned cycles and issued instructions are counted here, so the cost of an instruction is its count delta
  always @(posedge mclk) begin
    if (nop_cycle === 1'h1) nops <= nops + 1;
    if (op_valid === 1'h1) ops <= ops + 1;
    if (op_valid === 1'h1) last_nop <= op_nop;
    if (icyc_tick === 1'h1) ticks <= ticks + 1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic hang(input int i);
    if (i >= 50) begin
      err_count++;
      $display("Error %0t: wait ran out", $time);
      test_done();
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (pready !== 1'h1 && i < 50);
    hang(i);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // The word stays offered until a take edge; valid is dropped by the caller after the last word
  task automatic feed(input mcuid_word_t w);
    int i;
    fetch_word <= w;
    fetch_valid <= 1'h1;
    i = 0;
    do begin
      @(negedge mclk);
      i++;
    end while (fetch_ready !== 1'h1 && i < 50);
    hang(i);
    @(posedge mclk);
  endtask
  task automatic exec(input mcuid_word_t ws[$], input int en, input int eo);
    int n0;
    int o0;
    n0 = nops;
    o0 = ops;
    foreach (ws[i]) feed(ws[i]);
    fetch_valid <= 1'h0;
    repeat (8) @(posedge mclk);
    chk(nops - n0, en);
    chk(ops - o0, eo);
  endtask
  task automatic t_regs;
    apb(1'h1, 12'h000, 32'h0000_0001);
    apb(1'h0, 12'h000, 32'h0);
    chk(rd, 32'h1);
    apb(1'h0, 12'h100, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'h1, 12'h044, 32'h0000_8001);
    apb(1'h0, 12'h044, 32'h0);
    chk(rd, 32'h8001);
    $display("test regs done");
  endtask
  task automatic t_timing;
    exec('{24'h400000}, 0, 1);
    exec('{24'h370000}, 1, 1);
    // Flags are clear here: carry-set fails, carry-clear succeeds
    exec('{24'h300000}, 0, 1);
    exec('{24'h340000}, 1, 1);
    exec('{24'h010000}, 1, 1);
    exec('{24'h060000}, 2, 1);
    exec('{24'h070000}, 2, 1);
    exec('{24'hBA0000}, 1, 1);
    exec('{24'hBB0000}, 1, 1);
    exec('{24'hBE0000}, 1, 1);
    $display("test timing done");
  endtask
  task automatic t_two_word;
    exec('{24'h04ABCD, 24'h00005A}, 0, 1);
    chk(op_two_word, 1'h1);
    chk(op_ext, 24'h00005A);
    chk(op_prog_addr, {7'h5A, 15'h55E6, 1'h0});
    chk(op_slit, 16'h005A);
    exec('{24'h020000, 24'h010000}, 0, 1);
    apb(1'h0, 12'h004, 32'h0);
    chk(rd[8], 1'h1);
    apb(1'h1, 12'h004, 32'h0000_0100);
    apb(1'h0, 12'h004, 32'h0);
    chk(rd[8], 1'h0);
    exec('{24'h00ABCD}, 0, 1);
    chk(last_nop, 1'h1);
    $display("test two-word done");
  endtask
  task automatic t_skip;
    exec('{24'hA6F001, 24'h400000}, 1, 1);
    chk(op_bit_pos, 4'hF);
    exec('{24'hA6F001, 24'h020000, 24'h000000}, 2, 1);
    exec('{24'hA7F001, 24'h400000}, 0, 2);
    $display("test skip done");
  endtask
  task automatic t_fields;
    exec('{24'hE03FFF}, 0, 1);
    chk(op_file_addr, 13'h1FFF);
    chk(op_dst_reg, 4'h0);
    exec('{24'h433FF0}, 0, 1);
    chk(op_ulit, 16'h03FF);
    chk(op_size, SZ_WORD);
    exec('{24'h413FF0}, 0, 1);
    chk(op_ulit, 16'h00FF);
    chk(op_size, SZ_BYTE);
    exec('{24'h420000}, 0, 1);
    chk(op_size, SZ_DOUBLE);
    exec('{24'hB80003}, 0, 1);
    chk(op_src_reg, 4'h7);
    exec('{24'h40586F}, 0, 1);
    chk(op_src_reg, 4'hF);
    chk(op_src_mode, AM_REGOFS);
    chk(op_base_reg, 4'hB);
    // Both mode fields ask for indirect, so only the divide restriction can make them direct
    exec('{24'hD80810}, 0, 1);
    chk(op_src_mode, AM_DIRECT);
    chk(op_dst_mode, AM_DIRECT);
    $display("test fields done");
  endtask
  task automatic t_flags;
    alu_flags <= 5'h1F;
    alu_flag_we <= 1'h1;
    @(posedge mclk);
    alu_flags <= 5'h00;
    alu_sticky <= 1'h1;
    @(negedge mclk);
    chk(status_flags, 5'h1F);
    @(posedge mclk);
    alu_flags <= 5'h10;
    @(posedge mclk);
    alu_flag_we <= 1'h0;
    alu_sticky <= 1'h0;
    @(negedge mclk);
    chk(status_flags, 5'h00);
    $display("test flags done");
  endtask
  // Cycle counter first at full rate, then a divided instruction cycle of two clocks
  task automatic t_div;
    logic [31:0] c0;
    int t0;
    apb(1'h0, 12'h00C, 32'h0);
    c0 = rd;
    apb(1'h0, 12'h00C, 32'h0);
    chk(rd - c0, 32'h3);
    apb(1'h1, 12'h000, 32'h0000_0101);
    apb(1'h0, 12'h008, 32'h0);
    c0 = rd;
    t0 = ticks;
    repeat (8) @(posedge mclk);
    chk(ticks - t0, 32'h4);
    exec('{24'h400000, 24'h400000}, 0, 2);
    apb(1'h0, 12'h008, 32'h0);
    chk(rd - c0, 32'h2);
    $display("test div done");
  endtask
  initial begin
    arst_n = 1'h0;
    {psel, penable, pwrite, fetch_valid, alu_flag_we, alu_sticky} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    alu_flags = 5'h00;
    fetch_word = 24'h000000;
    repeat (10) @(posedge mclk);
    arst_n <= 1'h1;
    t_regs();
    t_timing();
    t_two_word();
    t_skip();
    t_fields();
    @(posedge mclk);
    t_flags();
    t_div();
    test_done();
  end
endmodule
`default_nettype wire
